// File: sce_core.v
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "sce_map.vh"

module sce_core (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // program memory
  output reg  [11:0] rom_addr,
  input  wire [7:0]  rom_data,
  // quasi ports
  input  wire [7:0]  port1_in,
  input  wire [7:0]  port2_in,
  output reg  [7:0]  port1_out,
  output reg  [7:0]  port2_out,
  // expander
  output reg         exp_strobe,
  output reg  [1:0]  exp_op,
  output reg  [1:0]  exp_sel,
  output reg  [3:0]  exp_data,
  input  wire [3:0]  exp_in,
  // host data buffer
  input  wire        host_wr_strobe,
  input  wire [7:0]  host_wr_data,
  input  wire        host_rd_strobe,
  output reg  [7:0]  host_data_buffer,
  output reg         host_in_full_flag,
  output reg         host_out_full_flag,
  // timer
  input  wire        count_event,
  output reg         timer_irq,
  // axi4-lite slave
  input  wire [3:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [3:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready
);

  localparam S_FETCH  = 2'b01;
  localparam S_SECOND = 2'b10;

  reg  [1:0]  state;
  reg  [11:0] pc;
  reg  [11:0] next_pc;
  reg  [7:0]  opcode;
  reg  [7:0]  acc;
  reg  [3:0]  psw_hi;
  reg  [2:0]  stack_pointer;
  reg         user_flag_one;
  reg         memory_bank_select;
  reg         run;
  reg         timer_interrupt_enable;
  reg  [1:0]  timer_mode;
  reg  [7:0]  timer;
  reg  [4:0]  prescale;
  reg         event_prev;
  reg  [7:0]  host_data_buffer_in;
  reg  [7:0]  data_mem [0:63];
  reg  [3:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         aw_got;
  reg         w_got;
  reg  [31:0] rd_word;
  reg         rd_ok;

  wire [11:0] pc_inc = pc + 12'h001;
  wire        carry = psw_hi[`SCE_PSW_CARRY];
  wire [5:0]  fetch_reg_idx = {3'h0, rom_data[2:0]};
  wire [7:0]  ind_ptr = data_mem[{5'h00, rom_data[0]}];
  wire [5:0]  ind_idx = ind_ptr[5:0];
  wire [7:0]  stack_lo = data_mem[stack_addr(stack_pointer, 1'b0)];
  wire [7:0]  stack_hi = data_mem[stack_addr(stack_pointer, 1'b1)];
  wire        reg_wr = aw_got & w_got & ~bvalid;
  wire        fetch_go = (state == S_FETCH) & run;
  wire        timer_tick = ((timer_mode == `SCE_TM_TIME) & (prescale == `SCE_TIMER_TC)) |
                           ((timer_mode == `SCE_TM_EVENT) & count_event & ~event_prev);

  // data memory address of one stack byte
  function [5:0] stack_addr;
    input [2:0] sp;
    input       hi;
    begin
      stack_addr = `SCE_STACK_BASE + {2'h0, sp, hi};
    end
  endfunction

  // opcodes needing a second machine cycle
  function is_long;
    input [7:0] op;
    begin
      casez (op)
        `OP_JUMP_USER, `OP_JUMP_DIRECT, `OP_JUMP_PAGE, `OP_JUMP_NO_CARRY,
        `OP_JUMP_IN_EMPTY, `OP_JUMP_OUT_FULL, `OP_PORT_AND, `OP_PORT_OR,
        `OP_EXP_AND, `OP_PORT_IN, `OP_EXP_READ, `OP_CALL, `OP_RET,
        `OP_RET_RESTORE: is_long = 1'b1;
        default:         is_long = 1'b0;
      endcase
    end
  endfunction

  // next program counter
  always @* begin
    next_pc = pc;
    if (state == S_FETCH) begin
      if (run)
        next_pc = pc_inc;
    end else begin
      next_pc = pc_inc;
      casez (opcode)
        `OP_JUMP_USER:
          if (user_flag_one)
            next_pc = {pc[11:8], rom_data};
        `OP_JUMP_DIRECT: next_pc = {memory_bank_select, opcode[7:5], rom_data};
        `OP_JUMP_PAGE:   next_pc = {pc[11:8], rom_data};
        `OP_JUMP_NO_CARRY:
          if (!carry)
            next_pc = {pc[11:8], rom_data};
        `OP_JUMP_IN_EMPTY:
          if (!host_in_full_flag)
            next_pc = {pc[11:8], rom_data};
        `OP_JUMP_OUT_FULL:
          if (host_out_full_flag)
            next_pc = {pc[11:8], rom_data};
        `OP_CALL: next_pc = {memory_bank_select, opcode[7:5], rom_data};
        `OP_RET, `OP_RET_RESTORE: next_pc = {stack_hi[3:0], stack_lo};
        // one-byte two-cycle ops already advanced the pc at fetch
        `OP_PORT_IN, `OP_EXP_READ, `OP_EXP_AND: next_pc = pc;
        default: next_pc = pc_inc;
      endcase
    end
  end

  // instruction execution, timer and host flags
  always @(posedge clk) begin
    if (reset) begin
      state                  <= S_FETCH;
      pc                     <= `SCE_PC_RESET;
      rom_addr               <= `SCE_PC_RESET;
      opcode                 <= `SCE_BYTE_RESET;
      acc                    <= `SCE_BYTE_RESET;
      psw_hi                 <= `SCE_NIB_RESET;
      stack_pointer          <= 3'h0;
      user_flag_one          <= 1'b0;
      memory_bank_select     <= 1'b0;
      run                    <= 1'b0;
      timer_interrupt_enable <= 1'b0;
      timer_mode             <= `SCE_TM_STOP;
      timer                  <= `SCE_BYTE_RESET;
      prescale               <= 5'h00;
      event_prev             <= 1'b0;
      timer_irq              <= 1'b0;
      port1_out              <= `SCE_BYTE_RESET;
      port2_out              <= `SCE_BYTE_RESET;
      exp_strobe             <= 1'b0;
      exp_op                 <= `SCE_EXP_READ;
      exp_sel                <= 2'h0;
      exp_data               <= `SCE_NIB_RESET;
      host_data_buffer       <= `SCE_BYTE_RESET;
      host_data_buffer_in    <= `SCE_BYTE_RESET;
      host_in_full_flag      <= 1'b0;
      host_out_full_flag     <= 1'b0;
    end else begin
      exp_strobe <= 1'b0;
      pc         <= next_pc;
      if (fetch_go && rom_data == `OP_JUMP_PAGE)
        rom_addr <= {pc_inc[11:8], acc};
      else
        rom_addr <= next_pc;
      // timer source and overflow
      event_prev <= count_event;
      if (timer_mode == `SCE_TM_TIME && prescale != `SCE_TIMER_TC)
        prescale <= prescale + 5'h01;
      else
        prescale <= 5'h00;
      if (timer_tick)
        timer <= timer + 8'h01;
      timer_irq <= timer_tick & (timer == `SCE_TIMER_TOP) & timer_interrupt_enable;
      // host strobes
      if (host_wr_strobe)
        host_data_buffer_in <= host_wr_data;
      if (host_rd_strobe)
        host_out_full_flag <= 1'b0;
      // software control write
      if (reg_wr && aw_addr_q == `SCE_REG_CONTROL && w_strb_q[0]) begin
        run                <= w_data_q[`SCE_CTL_RUN];
        user_flag_one      <= w_data_q[`SCE_CTL_USER_FLAG];
        memory_bank_select <= w_data_q[`SCE_CTL_BANK];
        psw_hi             <= w_data_q[7:4];
      end
      case (state)
        S_FETCH: begin
          if (run) begin
            opcode <= rom_data;
            if (is_long(rom_data))
              state <= S_SECOND;
            casez (rom_data)
              `OP_EXP_READ: begin
                exp_strobe <= 1'b1;
                exp_op     <= `SCE_EXP_READ;
                exp_sel    <= rom_data[1:0];
              end
              `OP_EXP_WRITE, `OP_EXP_OR, `OP_EXP_AND: begin
                exp_strobe <= 1'b1;
                exp_sel    <= rom_data[1:0];
                exp_data   <= acc[3:0];
                if (rom_data[5])
                  exp_op <= `SCE_EXP_WRITE;
                else if (rom_data[4])
                  exp_op <= `SCE_EXP_AND;
                else
                  exp_op <= `SCE_EXP_OR;
              end
              `OP_HOST_IN: begin
                acc               <= host_data_buffer_in;
                host_in_full_flag <= 1'b0;
              end
              `OP_HOST_OUT: begin
                host_data_buffer   <= acc;
                host_out_full_flag <= 1'b1;
              end
              `OP_PORT_LATCH: begin
                if (rom_data[1:0] == `SCE_SEL_PORT1)
                  port1_out <= acc;
                else if (rom_data[1:0] == `SCE_SEL_PORT2)
                  port2_out <= acc;
              end
              `OP_REG_DEC:
                data_mem[fetch_reg_idx] <= data_mem[fetch_reg_idx] - 8'h01;
              `OP_REG_INC:
                data_mem[fetch_reg_idx] <= data_mem[fetch_reg_idx] + 8'h01;
              `OP_IND_INC:
                data_mem[ind_idx] <= data_mem[ind_idx] + 8'h01;
              `OP_RET, `OP_RET_RESTORE:
                stack_pointer <= stack_pointer - 3'h1;
              `OP_TIMER_IE_ON:   timer_interrupt_enable <= 1'b1;
              `OP_TIMER_IE_OFF:  timer_interrupt_enable <= 1'b0;
              `OP_TIMER_TO_ACC:  acc <= timer;
              `OP_ACC_TO_TIMER:  timer <= acc;
              `OP_COUNTER_STOP:  timer_mode <= `SCE_TM_STOP;
              `OP_COUNTER_START: timer_mode <= `SCE_TM_EVENT;
              `OP_TIMER_START:   timer_mode <= `SCE_TM_TIME;
              default: ;
            endcase
          end
        end
        S_SECOND: begin
          state <= S_FETCH;
          casez (opcode)
            `OP_PORT_AND: begin
              if (opcode[1:0] == `SCE_SEL_PORT1)
                port1_out <= port1_out & rom_data;
              else if (opcode[1:0] == `SCE_SEL_PORT2)
                port2_out <= port2_out & rom_data;
            end
            `OP_PORT_OR: begin
              if (opcode[1:0] == `SCE_SEL_PORT1)
                port1_out <= port1_out | rom_data;
              else if (opcode[1:0] == `SCE_SEL_PORT2)
                port2_out <= port2_out | rom_data;
            end
            `OP_PORT_IN: begin
              if (opcode[1:0] == `SCE_SEL_PORT1)
                acc <= port1_in;
              else if (opcode[1:0] == `SCE_SEL_PORT2)
                acc <= port2_in;
            end
            `OP_EXP_READ: acc <= {4'h0, exp_in};
            `OP_CALL: begin
              data_mem[stack_addr(stack_pointer, 1'b0)] <= pc_inc[7:0];
              data_mem[stack_addr(stack_pointer, 1'b1)] <= {psw_hi, pc_inc[11:8]};
              stack_pointer <= stack_pointer + 3'h1;
            end
            `OP_RET_RESTORE: psw_hi <= stack_hi[7:4];
            default: ;
          endcase
        end
        default:
          state <= S_FETCH;
      endcase
      // a host write in the clearing cycle still marks the buffer full
      if (host_wr_strobe)
        host_in_full_flag <= 1'b1;
    end
  end

  // register read mux
  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (araddr)
      `SCE_REG_CONTROL: rd_word = {24'h00_0000, psw_hi, 1'b0, memory_bank_select, user_flag_one, run};
      `SCE_REG_STATUS:
        rd_word = {acc, 3'h0, timer_mode, timer_interrupt_enable,
                   host_out_full_flag, host_in_full_flag, 4'h0, pc};
      `SCE_REG_TIMER: rd_word = {16'h0000, host_data_buffer, timer};
      default: rd_ok = 1'b0;
    endcase
  end

  // axi4-lite write and read channels
  always @(posedge clk) begin
    if (reset) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= `SCE_RESP_OKAY;
      aw_got    <= 1'b0;
      w_got     <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      arready   <= 1'b1;
      rvalid    <= 1'b0;
      rdata     <= 32'h0000_0000;
      rresp     <= `SCE_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr_q <= awaddr;
        aw_got    <= 1'b1;
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        w_got    <= 1'b1;
        wready   <= 1'b0;
      end
      if (reg_wr) begin
        bvalid <= 1'b1;
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bresp  <= (aw_addr_q == `SCE_REG_CONTROL) ? `SCE_RESP_OKAY : `SCE_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_word;
        rresp   <= rd_ok ? `SCE_RESP_OKAY : `SCE_RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule // sce_core

`default_nettype wire

// File: sce_map.vh
`ifndef SCE_MAP_VH
`define SCE_MAP_VH

// register byte offsets (4-bit bus address)
`define SCE_REG_CONTROL    4'h0
`define SCE_REG_STATUS     4'h4
`define SCE_REG_TIMER      4'h8

// control register bit positions
`define SCE_CTL_RUN        0
`define SCE_CTL_USER_FLAG  1
`define SCE_CTL_BANK       2

// carry position inside the upper status nibble
`define SCE_PSW_CARRY      3

// bus responses
`define SCE_RESP_OKAY      2'h0
`define SCE_RESP_SLVERR    2'h2

// reset values
`define SCE_PC_RESET       12'h000
`define SCE_BYTE_RESET     8'h00
`define SCE_NIB_RESET      4'h0

// data memory layout: stack starts above working registers
`define SCE_STACK_BASE     6'h08

// internal timer prescale terminal count (divide by 32)
`define SCE_TIMER_TC       5'h1f
`define SCE_TIMER_TOP      8'hff

// timer modes
`define SCE_TM_STOP        2'h0
`define SCE_TM_EVENT       2'h1
`define SCE_TM_TIME        2'h2

// expander operations
`define SCE_EXP_READ       2'h0
`define SCE_EXP_WRITE      2'h1
`define SCE_EXP_OR         2'h2
`define SCE_EXP_AND        2'h3

// port selects
`define SCE_SEL_PORT1      2'h1
`define SCE_SEL_PORT2      2'h2

// opcodes
`define OP_NOP             8'b0000_0000
`define OP_JUMP_USER       8'b0111_0110
`define OP_JUMP_DIRECT     8'b???0_0100
`define OP_JUMP_PAGE       8'b1011_0011
`define OP_JUMP_NO_CARRY   8'b1110_0110
`define OP_JUMP_IN_EMPTY   8'b1101_0110
`define OP_JUMP_OUT_FULL   8'b1000_0110
`define OP_PORT_AND        8'b1001_10??
`define OP_PORT_OR         8'b1000_10??
`define OP_EXP_AND         8'b1001_11??
`define OP_EXP_OR          8'b1000_11??
`define OP_PORT_IN         8'b0000_10??
`define OP_HOST_IN         8'b0010_0010
`define OP_EXP_READ        8'b0000_11??
`define OP_EXP_WRITE       8'b0011_11??
`define OP_HOST_OUT        8'b0000_0010
`define OP_PORT_LATCH      8'b0011_10??
`define OP_REG_DEC         8'b1100_1???
`define OP_REG_INC         8'b0001_1???
`define OP_IND_INC         8'b0001_000?
`define OP_CALL            8'b???1_0100
`define OP_RET             8'b1000_0011
`define OP_RET_RESTORE     8'b1001_0011
`define OP_TIMER_IE_ON     8'b0010_0101
`define OP_TIMER_IE_OFF    8'b0011_0101
`define OP_TIMER_TO_ACC    8'b0100_0010
`define OP_ACC_TO_TIMER    8'b0110_0010
`define OP_COUNTER_STOP    8'b0110_0101
`define OP_COUNTER_START   8'b0100_0101
`define OP_TIMER_START     8'b0101_0101

`endif

// File: sce_core_checker.sv
`timescale 1ns/100ps
`default_nettype none
module sce_core_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // program bytes and port latch
  input wire logic [7:0] rom_data,
  input wire logic [7:0] port1_out,
  // host buffer
  input wire logic       host_wr_strobe,
  input wire logic [7:0] host_data_buffer,
  input wire logic       host_in_full_flag,
  input wire logic       host_out_full_flag,
  // expander
  input wire logic       exp_strobe,
  input wire logic [1:0] exp_op,
  input wire logic [1:0] exp_sel,
  input wire logic [3:0] exp_data,
  // write channels
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic       bvalid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_in_set; $rose(host_in_full_flag) |-> $past(host_wr_strobe); endproperty
  a_in_set: assert property (p_in_set) else $error("input flag rose without host write");
  property p_in_clr; $fell(host_in_full_flag) |-> $past(rom_data) == 8'h22 && !$past(host_wr_strobe); endproperty
  a_in_clr: assert property (p_in_clr) else $error("input flag fell without buffer input");
  property p_out_set; $rose(host_out_full_flag) |-> $past(rom_data) == 8'h02; endproperty
  a_out_set: assert property (p_out_set) else $error("output flag rose without buffer output");
  property p_buf; $changed(host_data_buffer) |-> host_out_full_flag && $past(rom_data) == 8'h02; endproperty
  a_buf: assert property (p_buf) else $error("host buffer changed outside buffer output");
  property p_port1;
    $changed(port1_out) |-> $past(rom_data) == 8'h39 || $past(rom_data, 2) inside {8'h89, 8'h99};
  endproperty
  a_port1: assert property (p_port1) else $error("port 1 changed without a port opcode");
  property p_exp_src;
    exp_strobe |-> $past(rom_data[3:2]) == 2'b11 && exp_sel == $past(rom_data[1:0]);
  endproperty
  a_exp_src: assert property (p_exp_src) else $error("expander strobe select wrong");
  property p_exp_op; exp_strobe |-> exp_op == {$past(rom_data[7]), $past(rom_data[4])}; endproperty
  a_exp_op: assert property (p_exp_op) else $error("expander operation code wrong");
  property p_exp_hold; !exp_strobe |-> $stable(exp_data); endproperty
  a_exp_hold: assert property (p_exp_hold) else $error("expander data moved between strobes");
  property p_bresp; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
  a_bresp: assert property (p_bresp) else $error("write response late");
endmodule // sce_core_checker

bind sce_core sce_core_checker u_checker (.clk(clk), .reset(reset), .rom_data(rom_data), .port1_out(port1_out),
  .host_wr_strobe(host_wr_strobe), .host_data_buffer(host_data_buffer), .host_in_full_flag(host_in_full_flag),
  .host_out_full_flag(host_out_full_flag), .exp_strobe(exp_strobe), .exp_op(exp_op), .exp_sel(exp_sel),
  .exp_data(exp_data), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid));
`default_nettype wire

// File: sce_host.sv
`timescale 1ns/100ps
`default_nettype none
module sce_host (
  // clock
  input  wire logic       clk,
  // host side of the data buffer
  output var  logic       host_wr_strobe,
  output var  logic [7:0] host_wr_data,
  output var  logic       host_rd_strobe,
  input  wire logic [7:0] host_data_buffer
);
  initial begin
    host_wr_strobe = 1'b0;
    host_wr_data   = 8'h00;
    host_rd_strobe = 1'b0;
  end
  // one-cycle write strobe, bus shows garbage once released
  task automatic send(input logic [7:0] d);
    @(posedge clk);
    host_wr_strobe <= 1'b1;
    host_wr_data   <= d;
    @(posedge clk);
    host_wr_strobe <= 1'b0;
    host_wr_data   <= ~d;
  endtask
  // one-cycle read strobe, byte taken at the strobe edge
  task automatic fetch(output logic [7:0] d);
    @(posedge clk);
    host_rd_strobe <= 1'b1;
    @(posedge clk);
    d = host_data_buffer;
    host_rd_strobe <= 1'b0;
  endtask
endmodule // sce_host
`default_nettype wire

// File: sce_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "sce_map.vh"
module sce_core_tb;
  logic        clk = 1'b0, reset = 1'b1, count_event = 1'b0;
  logic [11:0] rom_addr;
  logic [7:0]  rom_data, port1_out, port2_out, host_wr_data, host_data_buffer, hb;
  logic [7:0]  port1_in = 8'h40, port2_in = 8'hc3;
  logic        exp_strobe, host_wr_strobe, host_rd_strobe, host_in_full_flag, host_out_full_flag, timer_irq;
  logic [1:0]  exp_op, exp_sel, bresp, rresp, rs;
  logic [3:0]  exp_data, exp_in = 4'h9, awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [7:0]  rom [0:4095];
  logic [15:0] exp_log = 16'h0000;
  int          fail_count = 0, n_compared = 0, cycles = 0, irq_count = 0;

  always #10 clk = ~clk;
  assign rom_data = rom[rom_addr];

  sce_core dut (.clk(clk), .reset(reset), .rom_addr(rom_addr), .rom_data(rom_data), .port1_in(port1_in),
    .port2_in(port2_in), .port1_out(port1_out), .port2_out(port2_out), .exp_strobe(exp_strobe),
    .exp_op(exp_op), .exp_sel(exp_sel), .exp_data(exp_data), .exp_in(exp_in), .host_wr_strobe(host_wr_strobe),
    .host_wr_data(host_wr_data), .host_rd_strobe(host_rd_strobe), .host_data_buffer(host_data_buffer),
    .host_in_full_flag(host_in_full_flag), .host_out_full_flag(host_out_full_flag), .count_event(count_event),
    .timer_irq(timer_irq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  sce_host host (.clk(clk), .host_wr_strobe(host_wr_strobe), .host_wr_data(host_wr_data),
    .host_rd_strobe(host_rd_strobe), .host_data_buffer(host_data_buffer));

  // expander strobe log, interrupt count and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (exp_strobe) exp_log <= {exp_log[11:0], exp_op, exp_sel};
    if (timer_irq) irq_count <= irq_count + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // poll a register until the masked field matches, bounded
  task automatic poll(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    do begin
      axi_rd(a, rd, rs);
      k++;
    end while ((rd & m) !== v && k < 100);
  endtask

  task automatic load(input logic [11:0] a, input logic [127:0] v, input int n);
    for (int i = 0; i < n; i++) rom[a + i] = v[8 * (n - 1 - i) +: 8];
  endtask

  task automatic restart;
    @(posedge clk);
    reset <= 1'b1;
    foreach (rom[i]) rom[i] = 8'h00;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
  endtask

  initial begin
    foreach (rom[i]) rom[i] = 8'h00;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    // reset state and refused accesses
    axi_rd(`SCE_REG_STATUS, rd, rs); chk("status at reset", 32'h0, rd);
    axi_rd(4'hc, rd, rs); chk("unmapped read resp", {30'h0, `SCE_RESP_SLVERR}, {30'h0, rs});
    axi_wr(`SCE_REG_STATUS, 32'hffffffff, rs); chk("read-only write resp", {30'h0, `SCE_RESP_SLVERR}, {30'h0, rs});
    // low byte lane off: control must keep its reset value
    wstrb <= 4'he;
    axi_wr(`SCE_REG_CONTROL, 32'hff, rs);
    wstrb <= 4'hf;
    axi_rd(`SCE_REG_CONTROL, rd, rs); chk("masked control write", 32'h0, rd);
    // buffer, port and expander traffic with a call and return
    load(12'h000, 128'hd6_00_22_02_86_08_04_06, 8);
    load(12'h008, 128'h39_89_81_8a_f0_9a_30_3d_8d_9e_0e_14_20_1b_cc_00, 16);
    load(12'h018, 128'h04_18, 2);
    load(12'h020, 128'h83, 1);
    host.send(8'h5a);
    axi_rd(`SCE_REG_STATUS, rd, rs); chk("input full set", 32'h0001_0000, rd);
    axi_wr(`SCE_REG_CONTROL, 32'h1, rs);
    poll(`SCE_REG_STATUS, 32'hfff, 32'h018);
    chk("status a", 32'h0902_0018, rd);
    chk("port 1", 32'hdb, {24'h0, port1_out});
    chk("port 2", 32'h30, {24'h0, port2_out});
    chk("expander ops", 32'h59e2, {16'h0, exp_log});
    chk("expander data", 32'ha, {28'h0, exp_data});
    axi_rd(`SCE_REG_TIMER, rd, rs); chk("host buffer", 32'h5a00, rd);
    host.fetch(hb); chk("host read", 32'h5a, {24'h0, hb});
    poll(`SCE_REG_STATUS, 32'hfff, 32'h018); chk("output full cleared", 32'h0900_0018, rd);
    // flag loop, restoring return, indirect and banked jumps, event count
    restart();
    load(12'h000, 128'hd6_04_04_02_86_02_09_14_30_e6_20_b3, 12);
    load(12'h030, 128'h76_30_93, 3);
    load(12'h040, 128'h50, 1);
    load(12'h050, 128'h62_45_25_04_53, 5);
    load(12'h853, 128'h04_53, 2);
    axi_wr(`SCE_REG_CONTROL, 32'ha3, rs);
    poll(`SCE_REG_STATUS, 32'hfff, 32'h030); chk("flag loop pc", 32'h030, {20'h0, rd[11:0]});
    axi_wr(`SCE_REG_CONTROL, 32'h05, rs);
    poll(`SCE_REG_STATUS, 32'hfff, 32'h853);
    chk("status b", 32'h400c_0853, rd);
    axi_rd(`SCE_REG_CONTROL, rd, rs); chk("restored status", 32'ha5, rd);
    repeat (3) begin
      @(posedge clk) count_event <= 1'b1;
      repeat (2) @(posedge clk);
      count_event <= 1'b0;
      @(posedge clk);
    end
    axi_rd(`SCE_REG_TIMER, rd, rs); chk("event count", 32'h43, rd);
    // run the counter through its wrap with the interrupt enabled
    repeat (189) begin
      @(posedge clk) count_event <= 1'b1;
      @(posedge clk) count_event <= 1'b0;
    end
    axi_rd(`SCE_REG_TIMER, rd, rs); chk("event wrap", 32'h00, rd);
    chk("overflow interrupts", 32'h1, irq_count);
    // timer start, disable, stop
    restart();
    load(12'h000, 128'h00_25_42_55_35_76_05_65_04_08, 10);
    axi_wr(`SCE_REG_CONTROL, 32'h03, rs);
    poll(`SCE_REG_STATUS, 32'hfff, 32'h005); chk("status c", 32'h0010_0005, rd);
    poll(`SCE_REG_TIMER, 32'hff, 32'h01); chk("internal count", 32'h01, rd);
    axi_wr(`SCE_REG_CONTROL, 32'h01, rs);
    poll(`SCE_REG_STATUS, 32'hfff, 32'h008); chk("status stopped", 32'h0000_0008, rd);
    report_and_stop();
  end
endmodule // sce_core_tb
`default_nettype wire
